//--- design/bgp_pkg.sv
// Behaviour
// RL1: Direction bit one drives, zero receives.
// RL2: Input with latch one enables pull-up.
// RL3: Reset tri-states all pins without clock.
// RL4: Output drives latch value, pull-up off.
// RL5: Writing one to input register toggles latch.
// RL6: Global disable turns off every pull-up.
// RL7: Three registers: latch, direction, sampled levels.
// RL8: Bit set/clear touches only addressed bit.
// RL9: Sampled level readable in any direction.
// RL10: Latch on high clock, flop on rise.
// RL11: Pin change visible after half to 1.5 periods.
// RL12: Own written level readable after one period.
// RL13: Master idles one cycle before reading back.
// RL14: Tri-state to high passes intermediate state.
// RL15: Pull-up to low passes intermediate state.
// RL16: Per-pin logic keeps other pins unaffected.
// RL17: Sleep clamps input path low unless kept.
// RL18: Writes on clock edge, reads return storage.
// RL19: Pull-up disable and sleep are single inputs.
package bgp_pkg;
   localparam int unsigned BGP_WIDTH     = 8;
   localparam int unsigned BGP_ADDR_W    = 2;
   localparam int unsigned BGP_SEL_W     = 3;
   // Register offsets within the port
   localparam logic [1:0]  BGP_OFS_PIN   = 2'h0;
   localparam logic [1:0]  BGP_OFS_DIR   = 2'h1;
   localparam logic [1:0]  BGP_OFS_LATCH = 2'h2;
   // Values after reset, and the value read from an unmapped offset
   localparam logic [7:0]  BGP_RST_DIR   = 8'h00;
   localparam logic [7:0]  BGP_RST_LATCH = 8'h00;
   localparam logic [7:0]  BGP_RST_RDATA = 8'h00;
   localparam logic [7:0]  BGP_RST_SYNC  = 8'h00;
   localparam logic [7:0]  BGP_UNMAPPED  = 8'h00;
endpackage : bgp_pkg

//--- design/bgp_port.sv
`timescale 1ns/1ps
module bgp_port #(
   parameter int unsigned W = bgp_pkg::BGP_WIDTH
) (
   // Clock and reset
   input  wire logic                           i_mclk,
   input  wire logic                           i_rstn,
   // CPU I/O bus
   input  wire logic [bgp_pkg::BGP_ADDR_W-1:0] i_addr,
   input  wire logic                           i_wr,
   input  wire logic [W-1:0]                   i_wdata,
   input  wire logic                           i_rd,
   output logic      [W-1:0]                   o_rdata,
   // Single-bit set and clear
   input  wire logic                           i_bit_set,
   input  wire logic                           i_bit_clr,
   input  wire logic [bgp_pkg::BGP_SEL_W-1:0]  i_bit_sel,
   // Global controls
   input  wire logic                           i_pud,
   input  wire logic                           i_sleep,
   input  wire logic [W-1:0]                   i_din_keep,
   // Pins
   input  wire logic [W-1:0]                   i_pin,
   output logic      [W-1:0]                   o_pin_out,
   output logic      [W-1:0]                   o_pin_oe,
   output logic      [W-1:0]                   o_pullup_en
);
   logic [W-1:0] dir_q;
   logic [W-1:0] dir_d;
   logic [W-1:0] latch_q;
   logic [W-1:0] latch_d;
   logic [W-1:0] rdata_q;
   logic [W-1:0] rdata_d;
   logic [W-1:0] sampled;

   // Address decode
   wire          sel_pin   = (i_addr == bgp_pkg::BGP_OFS_PIN);
   wire          sel_dir   = (i_addr == bgp_pkg::BGP_OFS_DIR);
   wire          sel_latch = (i_addr == bgp_pkg::BGP_OFS_LATCH);
   wire [W-1:0]  bit_mask  = W'(1) << i_bit_sel;
   wire          bit_op    = !i_wr && (i_bit_set || i_bit_clr);
   wire          wr_pin    = i_wr && sel_pin;
   wire          wr_dir    = i_wr && sel_dir;
   wire          wr_latch  = i_wr && sel_latch;
   wire          set_dir   = bit_op && i_bit_set && sel_dir;
   wire          clr_dir   = bit_op && !i_bit_set && sel_dir;
   wire          set_latch = bit_op && i_bit_set && sel_latch;
   wire          clr_latch = bit_op && !i_bit_set && sel_latch;
   wire          set_pin   = bit_op && i_bit_set && sel_pin;

   // Full write wins over a bit operation in the same cycle
   assign dir_d = wr_dir  ? i_wdata :                          // [RL18]
                  set_dir ? (dir_q | bit_mask) :              // [RL8]
                  clr_dir ? (dir_q & ~bit_mask) :             // [RL8]
                  dir_q;

   // Toggle through the level register ignores direction
   assign latch_d = wr_latch  ? i_wdata :                      // [RL18]
                    wr_pin    ? (latch_q ^ i_wdata) :          // [RL5]
                    set_pin   ? (latch_q ^ bit_mask) :         // [RL5] [RL8]
                    set_latch ? (latch_q | bit_mask) :         // [RL8]
                    clr_latch ? (latch_q & ~bit_mask) :        // [RL8]
                    latch_q;

   // Sampled level is readable whatever the direction
   assign rdata_d = !i_rd     ? rdata_q :
                    sel_pin   ? sampled :                      // [RL9] [RL7]
                    sel_dir   ? dir_q :                        // [RL7] [RL18]
                    sel_latch ? latch_q :                      // [RL7] [RL18]
                    bgp_pkg::BGP_UNMAPPED;

   // Async reset clears direction, so pins float with no clock
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         dir_q   <= bgp_pkg::BGP_RST_DIR;   // [RL3]
         latch_q <= bgp_pkg::BGP_RST_LATCH; // [RL3]
         rdata_q <= bgp_pkg::BGP_RST_RDATA;
      end else begin
         dir_q   <= dir_d;
         latch_q <= latch_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_rdata = rdata_q;

   // Each pin built alone so one pin's setup cannot disturb another
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_pin
         assign o_pin_oe[g]    = dir_q[g];                       // [RL1] [RL16]
         assign o_pin_out[g]   = latch_q[g];                     // [RL4]
         assign o_pullup_en[g] = !dir_q[g] && latch_q[g] && !i_pud; // [RL2] [RL4] [RL6] [RL19]
      end
   endgenerate

   // Clamp ahead of the synchroniser stops floating inputs drawing current
   wire [W-1:0] pin_gated = i_pin & ~({W{i_sleep}} & ~i_din_keep); // [RL17] [RL19]

   // Latch then flop: half to one and a half periods of delay
   bgp_sync #(
      .W (W)
   ) u_sync (
      .i_mclk (i_mclk),
      .i_rstn (i_rstn),
      .i_d    (pin_gated),
      .o_q    (sampled)
   ); // [RL10] [RL11] [RL12]

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rstn);

   a_dir_write: assert property ( // [RL1]
      wr_dir |=> o_pin_oe == $past(i_wdata))
      else $error("direction write not seen on output enables");

   a_pud_all_off: assert property ( // [RL6]
      i_pud |-> o_pullup_en == '0)
      else $error("pull-up active while globally disabled");

   a_pullup_input: assert property ( // [RL2]
      !i_pud |-> o_pullup_en == (~o_pin_oe & o_pin_out))
      else $error("pull-up not matching input with latch one");

   a_out_no_pullup: assert property ( // [RL4]
      (o_pullup_en & o_pin_oe) == '0)
      else $error("pull-up active on a driven pin");

   a_toggle_write: assert property ( // [RL5]
      wr_pin |=> o_pin_out == ($past(o_pin_out) ^ $past(i_wdata)))
      else $error("level register write did not toggle latch");

   a_bit_set_only: assert property ( // [RL8]
      set_dir |=> o_pin_oe == ($past(o_pin_oe) | $past(bit_mask)))
      else $error("bit set disturbed other direction bits");

   a_read_latch: assert property ( // [RL7]
      i_rd && sel_latch |=> o_rdata == $past(latch_q))
      else $error("latch read returned wrong value");

   a_sync_delay: assert property ( // [RL11]
      !i_sleep && $stable(i_pin) ##1 !i_sleep && $stable(i_pin)
      |-> sampled == i_pin)
      else $error("stable pin not sampled within bound");

   a_sleep_clamp: assert property ( // [RL17]
      i_sleep && $stable(i_din_keep) |=> (sampled & ~$past(i_din_keep)) == '0)
      else $error("sleep clamp did not force sampled low");

   a_clamp_keep: assert property ( // [RL17]
      i_sleep |-> pin_gated == (i_pin & i_din_keep))
      else $error("sleep clamp ignored the keep mask");

   a_awake_pass: assert property ( // [RL17]
      !i_sleep |-> pin_gated == i_pin)
      else $error("input path gated while awake");

   a_bit_clear: assert property ( // [RL8]
      clr_dir |=> o_pin_oe == ($past(o_pin_oe) & ~$past(bit_mask)))
      else $error("bit clear disturbed other direction bits");

   a_latch_set: assert property ( // [RL8]
      set_latch |=> o_pin_out == ($past(o_pin_out) | $past(bit_mask)))
      else $error("bit set disturbed other latch bits");

   a_latch_clear: assert property ( // [RL8]
      clr_latch |=> o_pin_out == ($past(o_pin_out) & ~$past(bit_mask)))
      else $error("bit clear disturbed other latch bits");

   a_bit_toggle: assert property ( // [RL5]
      set_pin |=> o_pin_out == ($past(o_pin_out) ^ $past(bit_mask)))
      else $error("bit set on level register did not toggle");

   a_pin_clr_none: assert property ( // [RL5]
      bit_op && !i_bit_set && sel_pin |=> $stable(o_pin_out))
      else $error("bit clear on level register changed latch");

   a_latch_write: assert property ( // [RL18]
      wr_latch |=> o_pin_out == $past(i_wdata))
      else $error("latch write not seen on drive values");

   a_dir_hold: assert property ( // [RL8]
      !wr_dir && !set_dir && !clr_dir |=> $stable(o_pin_oe))
      else $error("direction changed without a request");

   a_latch_hold: assert property ( // [RL8]
      !wr_latch && !wr_pin && !set_pin && !set_latch && !clr_latch
      |=> $stable(o_pin_out))
      else $error("latch changed without a request");

   a_dir_only: assert property ( // [RL8]
      wr_dir |=> $stable(o_pin_out))
      else $error("direction write disturbed latch");

   a_latch_only: assert property ( // [RL8]
      wr_latch |=> $stable(o_pin_oe))
      else $error("latch write disturbed direction");

   a_pin_ro: assert property ( // [RL7]
      wr_pin |=> $stable(o_pin_oe))
      else $error("level register write changed direction");

   a_read_dir: assert property ( // [RL7]
      i_rd && sel_dir |=> o_rdata == $past(dir_q))
      else $error("direction read returned wrong value");

   a_read_pin: assert property ( // [RL9]
      i_rd && sel_pin |=> o_rdata == $past(sampled))
      else $error("level read returned wrong value");

   a_read_unmapped: assert property ( // [RL7]
      i_rd && !sel_pin && !sel_dir && !sel_latch |=> o_rdata == bgp_pkg::BGP_UNMAPPED)
      else $error("unmapped read returned nonzero");

   a_rdata_hold: assert property ( // [RL18]
      !i_rd |=> $stable(o_rdata))
      else $error("read data changed without a read");

   // Checked during reset itself, so the default disable is overridden
   a_reset_float: assert property ( // [RL3]
      disable iff (1'b0)
      !i_rstn |-> o_pin_oe == '0 && o_pullup_en == '0)
      else $error("pin driven or pulled during reset");

   c_toggle: cover property (wr_pin && i_wdata != '0);
   c_sleep_keep: cover property (i_sleep && i_din_keep != '0);
   c_bit_op: cover property (bit_op);
   c_pullup: cover property (o_pullup_en != '0);
   c_readback: cover property (wr_latch ##2 i_rd && sel_pin);
endmodule : bgp_port

//--- design/bgp_sync.sv
`timescale 1ns/1ps
module bgp_sync #(
   parameter int unsigned W = 8
) (
   // Clock and reset
   input  wire logic         i_mclk,
   input  wire logic         i_rstn,
   // Levels
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] lat;

   // Transparent while clock high, holds over the low phase
   always_latch begin
      if (i_mclk) begin
         lat <= i_d; // [RL10]
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_q <= bgp_pkg::BGP_RST_SYNC;
      end else begin
         o_q <= lat; // [RL10]
      end
   end
endmodule : bgp_sync

//--- testbench/bgp_pad.sv
`timescale 1ns/1ps
module bgp_pad (
   // Clock
   input  wire logic       i_mclk,
   // Device side
   input  wire logic [7:0] i_out,
   input  wire logic [7:0] i_oe,
   input  wire logic [7:0] i_pu,
   // External driver
   input  wire logic [7:0] i_ext_en,
   input  wire logic [7:0] i_ext_val,
   output logic      [7:0] o_level
);
   logic [7:0] float_q = 8'h00;
   // Undriven lines wander so stale values never pass
   always_ff @(posedge i_mclk) float_q <= ~float_q;
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         if (i_oe[n]) o_level[n] = i_out[n];
         else if (i_ext_en[n]) o_level[n] = i_ext_val[n];
         else if (i_pu[n]) o_level[n] = 1'b1;
         else o_level[n] = float_q[n];
      end
   end
endmodule : bgp_pad

//--- testbench/bidirectional_gpio_port_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module bidirectional_gpio_port_test;
   logic       i_mclk = 1'b0, i_rstn = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_pud = 1'b0;
   logic       i_bit_set = 1'b0, i_bit_clr = 1'b0, i_sleep = 1'b0;
   logic [1:0] i_addr = 2'h0;
   logic [2:0] i_bit_sel = 3'h0;
   logic [7:0] i_wdata = 8'h00, i_din_keep = 8'h00, ext_en = 8'hF0, ext_val = 8'hF0;
   logic [7:0] pin, o_rdata, o_pin_out, o_pin_oe, o_pullup_en, rv;
   int         fails = 0, check_count = 0;
   always #12.5 i_mclk = ~i_mclk;
   bgp_port DUT (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wr(i_wr),
      .i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata), .i_bit_set(i_bit_set),
      .i_bit_clr(i_bit_clr), .i_bit_sel(i_bit_sel), .i_pud(i_pud), .i_sleep(i_sleep),
      .i_din_keep(i_din_keep), .i_pin(pin), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
      .o_pullup_en(o_pullup_en));
   bgp_pad PAD (.i_mclk(i_mclk), .i_out(o_pin_out), .i_oe(o_pin_oe), .i_pu(o_pullup_en),
      .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(pin));
   task automatic finish_test;
      if (fails == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test
   task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= w;
      i_rd <= ~w;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      @(negedge i_mclk);
      rv = o_rdata;
   endtask : bus
   task automatic bop(input logic s, input logic [2:0] n);
      @(posedge i_mclk);
      i_addr <= 2'h1;
      i_bit_set <= s;
      i_bit_clr <= ~s;
      i_bit_sel <= n;
      @(posedge i_mclk);
      i_bit_set <= 1'b0;
      i_bit_clr <= 1'b0;
      @(negedge i_mclk);
   endtask : bop
   task automatic t_reset;
      `CHK("oe", 8'h00, o_pin_oe)
      `CHK("pu", 8'h00, o_pullup_en)
   endtask : t_reset
   task automatic t_pull;
      bus(1'b1, 2'h2, 8'hFF);
      `CHK("pu", 8'hFF, o_pullup_en)
      @(posedge i_mclk);
      i_pud <= 1'b1;
      @(negedge i_mclk);
      `CHK("pu off", 8'h00, o_pullup_en)
      @(posedge i_mclk);
      i_pud <= 1'b0;
      bus(1'b1, 2'h1, 8'h0F);
      `CHK("oe", 8'h0F, o_pin_oe)
      `CHK("pu out", 8'hF0, o_pullup_en)
   endtask : t_pull
   task automatic t_regs;
      bus(1'b0, 2'h1, 8'h00);
      `CHK("dir", 8'h0F, rv)
      bus(1'b0, 2'h3, 8'h00);
      `CHK("unmapped", 8'h00, rv)
   endtask : t_regs
   task automatic t_sync;
      @(posedge i_mclk);
      ext_val <= 8'hA0;
      i_addr <= 2'h0;
      i_rd <= 1'b1;
      @(negedge i_mclk);
      @(negedge i_mclk);
      `CHK("early", 8'hFF, o_rdata)
      @(posedge i_mclk);
      i_rd <= 1'b0;
      @(negedge i_mclk);
      `CHK("late", 8'hAF, o_rdata)
   endtask : t_sync
   task automatic t_toggle;
      bus(1'b1, 2'h0, 8'h0F);
      `CHK("out", 8'hF0, o_pin_out)
      bus(1'b0, 2'h0, 8'h00);
      `CHK("own", 8'hA0, rv)
      bus(1'b0, 2'h2, 8'h00);
      `CHK("latch", 8'hF0, rv)
   endtask : t_toggle
   task automatic t_bits;
      bop(1'b1, 3'h7);
      bop(1'b0, 3'h0);
      `CHK("dir", 8'h8E, o_pin_oe)
      `CHK("pu", 8'h70, o_pullup_en)
      `CHK("out", 8'hF0, o_pin_out)
   endtask : t_bits
   task automatic t_sleep;
      @(posedge i_mclk);
      i_sleep <= 1'b1;
      i_din_keep <= 8'h20;
      bus(1'b0, 2'h0, 8'h00);
      `CHK("sleep", 8'h20, rv)
      @(posedge i_mclk);
      i_sleep <= 1'b0;
   endtask : t_sleep
   task automatic t_async;
      @(posedge i_mclk);
      i_rstn <= 1'b0;
      #1;
      `CHK("rdata", 8'h00, o_rdata)
      `CHK("oe", 8'h00, o_pin_oe)
      `CHK("out", 8'h00, o_pin_out)
      `CHK("pu", 8'h00, o_pullup_en)
   endtask : t_async
   initial begin
      #100000;
      fails++;
      finish_test();
   end
   initial begin
      i_rstn <= 1'b0;
      repeat (5) @(posedge i_mclk);
      t_reset();
      i_rstn <= 1'b1;
      t_pull();
      t_regs();
      t_sync();
      t_toggle();
      t_bits();
      t_sleep();
      @(negedge i_mclk);
      t_async();
      finish_test();
   end
endmodule : bidirectional_gpio_port_test
